// *** verilog/stw_regs.svh ***
// register addresses, bit positions, reset values and timing counts of the serial port
`ifndef STW_REGS_SVH
`define STW_REGS_SVH

`define STW_ADDR_SPI_CTRL   8'hf8
`define STW_ADDR_SPI_DATA   8'hf7
`define STW_ADDR_TW_CTRL    8'he8
`define STW_ADDR_TW_DATA    8'h9a

`define STW_RST_SPI_CTRL    8'h04
`define STW_RST_SPI_DATA    8'h00
`define STW_RST_TW_CTRL     8'h00
`define STW_RST_TW_DATA     8'h00

`define STW_SPI_DONE_BIT    7
`define STW_SPI_WRITE_COLLISION_FLAG_BIT    6
`define STW_SPI_EN_BIT      5
`define STW_SPI_MASTER_BIT  4
`define STW_SPI_CLOCK_IDLE_LEVEL_BIT    3
`define STW_SPI_CLOCK_EDGE_PHASE_BIT    2
`define STW_SPI_RATE_HI_BIT 1
`define STW_SPI_RATE_LO_BIT 0

`define STW_TW_MDO_BIT      7
`define STW_TW_MDE_BIT      6
`define STW_TW_MCO_BIT      5
`define STW_TW_MDI_BIT      4
`define STW_TW_MASTER_BIT   3
`define STW_TW_RESET_BIT    2
`define STW_TW_DIR_BIT      1
`define STW_TW_FLAG_BIT     0

// half serial clock period in core cycles for each rate code
`define STW_HALF_RATE0      6'd4
`define STW_HALF_RATE1      6'd8
`define STW_HALF_RATE2      6'd16
`define STW_HALF_RATE3      6'd32
`define STW_BURST_EDGES     5'd16
`define STW_TW_SLAVE_ADDR   7'h55

`endif

// *** verilog/stw_pkg.sv ***
// types shared by the serial port design
`default_nettype none
package stw_pkg;
  typedef enum logic [2:0] {
    stw_tw_idle,
    stw_tw_addr,
    stw_tw_addr_ack,
    stw_tw_rx,
    stw_tw_rx_ack,
    stw_tw_tx,
    stw_tw_tx_ack
  } stw_tw_state_type;
endpackage
`default_nettype wire

// *** verilog/stw_link_shifter.sv ***
// slave-role byte shifter clocked by the external serial clock
`default_nettype none
module stw_link_shifter (
  input  wire logic       sclk_in,
  input  wire logic       link_rst_n,
  input  wire logic       core_rst_n,
  input  wire logic       edge_sel,
  input  wire logic       clock_edge_phase,
  input  wire logic [7:0] tx_byte,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output logic            rx_toggle
);
  logic       link_clk;
  logic [2:0] cnt;
  logic [6:0] rx_sh;
  logic       miso_q;

  // sample edge is always the rising edge of this clock; edge_sel must be static
  assign link_clk = sclk_in ^ edge_sel;

  // capture one bit per clock, msb first; hold full byte only at the eighth bit
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt   <= 3'd0;
      rx_sh <= 7'h00;
    end else begin
      cnt   <= cnt + 3'd1;
      rx_sh <= {rx_sh[5:0], mosi};
    end
  end

  // byte hold and toggle survive select release so the core can pick them up
  always_ff @(posedge link_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rx_byte   <= 8'h00;
      rx_toggle <= 1'b0;
    end else if (cnt == 3'd7) begin
      rx_byte   <= {rx_sh, mosi};
      rx_toggle <= ~rx_toggle;
    end
  end

  // launch on the other edge; tx_byte is held still by the core while selected
  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= tx_byte[3'd7 - cnt];
    end
  end

  // with phase 0 the first bit must stand before any edge arrives
  assign miso = (!clock_edge_phase && cnt == 3'd0) ? tx_byte[7] : miso_q;
endmodule
`default_nettype wire

// *** verilog/stw_serial_port.sv ***
// spi shifter and two-wire interface sharing one clock pin and one data pin
// Functional notes
// - master emits eight clocks per data write
// - master rate from two rate select bits
// - master ignores slave select pin
// - master shifts mosi out, samples miso
// - after eight clocks set done, load data
// - slave sends and captures one bit per clock
// - slave updates data only on full byte
// - byte end: eighth clock or select high
// - spi and two-wire share pins, one active
// - two-wire role: software master or hardware slave
// - software master drives data output bit
// - data output enable sets pin direction
// - software master drives clock output bit
// - data input latched on clock when undriven
// - reset bit holds two-wire slave idle
// - direction bit set while slave transmits
// - byte flag per byte, data read clears
// - done flag cleared by data read or control write
// - collision flag on write during transfer
// - clock idle level and launch edge select
// - role bit selects master or slave clock
`default_nettype none
`include "stw_regs.svh"
module stw_serial_port (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  input  wire logic       sclk_in,
  output logic            sclk_out,
  output logic            sclk_oe,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       ss_n
);
  logic [7:0] spi_ctrl;
  logic [7:0] spi_data;
  logic [7:0] tx_hold;
  logic [7:0] tw_ctrl;
  logic [7:0] tw_data;
  logic       spi_en, master, clock_idle_level, clock_edge_phase;
  logic       tw_sw, tw_hw;
  logic       wr_spi_ctrl, wr_spi_data, rd_spi_data, wr_tw_ctrl, wr_tw_data, rd_tw_data;
  logic [1:0] sclk_sy, serial_data_pin_sy, miso_sy, ss_sy, tog_sy;
  logic       scl_p, sda_p, tog_p;
  logic       m_busy, m_done, m_samp, m_sclk, m_mosi;
  logic [5:0] m_hcnt, half_period;
  logic [4:0] m_edge;
  logic [7:0] m_sh;
  logic       sl_byte, sl_pend, sl_complete, slave_busy;
  logic [7:0] sl_rx;
  logic       sl_miso, sl_tog, link_rst_n;
  stw_pkg::stw_tw_state_type tw_state;
  logic [3:0] tw_bcnt;
  logic [7:0] tw_sh;
  logic       tw_drv_low, tw_dir, tw_set_flag, tw_load;
  logic       scl_rise, scl_fall, tw_start, tw_stop;

  assign spi_en = spi_ctrl[`STW_SPI_EN_BIT];
  assign master = spi_ctrl[`STW_SPI_MASTER_BIT];
  assign clock_idle_level   = spi_ctrl[`STW_SPI_CLOCK_IDLE_LEVEL_BIT];
  assign clock_edge_phase   = spi_ctrl[`STW_SPI_CLOCK_EDGE_PHASE_BIT];
  assign tw_sw  = !spi_en && tw_ctrl[`STW_TW_MASTER_BIT];
  assign tw_hw  = !spi_en && !tw_ctrl[`STW_TW_MASTER_BIT];

  // sfr strobes
  assign wr_spi_ctrl = ce && sfr_wr && sfr_addr == `STW_ADDR_SPI_CTRL;
  assign wr_spi_data = ce && sfr_wr && sfr_addr == `STW_ADDR_SPI_DATA;
  assign rd_spi_data = ce && sfr_rd && sfr_addr == `STW_ADDR_SPI_DATA;
  assign wr_tw_ctrl  = ce && sfr_wr && sfr_addr == `STW_ADDR_TW_CTRL;
  assign wr_tw_data  = ce && sfr_wr && sfr_addr == `STW_ADDR_TW_DATA;
  assign rd_tw_data  = ce && sfr_rd && sfr_addr == `STW_ADDR_TW_DATA;

  // two-flop synchronisers for every pin and the link toggle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_sy  <= 2'b00;
      serial_data_pin_sy <= 2'b11;
      miso_sy  <= 2'b00;
      ss_sy    <= 2'b11;
      tog_sy   <= 2'b00;
    end else if (ce) begin
      sclk_sy  <= {sclk_sy[0], sclk_in};
      serial_data_pin_sy <= {serial_data_pin_sy[0], serial_data_pin_in};
      miso_sy  <= {miso_sy[0], miso_in};
      ss_sy    <= {ss_sy[0], ss_n};
      tog_sy   <= {tog_sy[0], sl_tog};
    end
  end

  // previous synchronised levels for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_p <= 1'b0;
      sda_p <= 1'b1;
      tog_p <= 1'b0;
    end else if (ce) begin
      scl_p <= sclk_sy[1];
      sda_p <= serial_data_pin_sy[1];
      tog_p <= tog_sy[1];
    end
  end

  // rate table; slower codes give longer half periods
  always_comb begin
    case (spi_ctrl[`STW_SPI_RATE_HI_BIT:`STW_SPI_RATE_LO_BIT])
      2'd0:    half_period = `STW_HALF_RATE0;
      2'd1:    half_period = `STW_HALF_RATE1;
      2'd2:    half_period = `STW_HALF_RATE2;
      default: half_period = `STW_HALF_RATE3;
    endcase
  end

  // master burst: sixteen half periods, leading edges even, trailing odd
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_busy <= 1'b0;
      m_done <= 1'b0;
      m_hcnt <= 6'd0;
      m_edge <= 5'd0;
      m_sh   <= 8'h00;
      m_samp <= 1'b0;
      m_sclk <= 1'b0;
      m_mosi <= 1'b0;
    end else if (ce) begin
      m_done <= 1'b0;
      if (!(spi_en && master)) begin
        m_busy <= 1'b0;
        m_sclk <= clock_idle_level;
      end else if (!m_busy) begin
        m_sclk <= clock_idle_level;
        if (wr_spi_data) begin
          m_busy <= 1'b1;
          m_sh   <= sfr_wdata;
          m_mosi <= sfr_wdata[7];
          m_hcnt <= 6'd0;
          m_edge <= 5'd0;
        end
      end else if (m_hcnt != half_period - 6'd1) begin
        m_hcnt <= m_hcnt + 6'd1;
      end else begin
        m_hcnt <= 6'd0;
        m_sclk <= ~m_sclk;
        m_edge <= m_edge + 5'd1;
        if (!m_edge[0]) begin
          if (clock_edge_phase) begin
            m_mosi <= m_sh[7];
          end else begin
            m_samp <= miso_sy[1];
          end
        end else begin
          m_sh <= {m_sh[6:0], clock_edge_phase ? miso_sy[1] : m_samp};
          if (!clock_edge_phase) begin
            m_mosi <= m_sh[6];
          end
          if (m_edge == `STW_BURST_EDGES - 5'd1) begin
            m_busy <= 1'b0;
            m_done <= 1'b1;
          end
        end
      end
    end
  end

  // slave link held in reset whenever unselected or not in slave role
  assign link_rst_n = nrst && !ss_n && spi_en && !master;

  stw_link_shifter u_link (
    .sclk_in    (sclk_in),
    .link_rst_n (link_rst_n),
    .core_rst_n (nrst),
    .edge_sel   (clock_idle_level ^ clock_edge_phase),
    .clock_edge_phase       (clock_edge_phase),
    .tx_byte    (tx_hold),
    .mosi       (serial_data_pin_in),
    .miso       (sl_miso),
    .rx_byte    (sl_rx),
    .rx_toggle  (sl_tog)
  );

  assign sl_byte     = tog_sy[1] != tog_p;
  // phase 1 ends at the eighth clock; phase 0 waits for select release
  assign sl_complete = spi_en && !master &&
                       ((clock_edge_phase && sl_byte) || (!clock_edge_phase && sl_pend && ss_sy[1]));
  assign slave_busy  = spi_en && !master && !ss_sy[1];

  // pending byte in phase 0 until select returns high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sl_pend <= 1'b0;
    end else if (ce) begin
      if (sl_byte && !clock_edge_phase) begin
        sl_pend <= 1'b1;
      end else if (sl_complete || master || !spi_en) begin
        sl_pend <= 1'b0;
      end
    end
  end

  // shift data register and transmit holding byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spi_data <= `STW_RST_SPI_DATA;
      tx_hold  <= `STW_RST_SPI_DATA;
    end else if (ce) begin
      if (m_done) begin
        spi_data <= m_sh;
      end else if (sl_complete) begin
        spi_data <= sl_rx;
      end
      if (wr_spi_data && !m_busy && !slave_busy) begin
        tx_hold <= sfr_wdata;
      end
    end
  end

  // spi control; hardware sets win over software clears
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spi_ctrl <= `STW_RST_SPI_CTRL;
    end else if (ce) begin
      if (wr_spi_ctrl) begin
        spi_ctrl <= sfr_wdata;
      end else if (rd_spi_data) begin
        spi_ctrl[`STW_SPI_DONE_BIT] <= 1'b0;
      end
      if (m_done || sl_complete) begin
        spi_ctrl[`STW_SPI_DONE_BIT] <= 1'b1;
      end
      if (wr_spi_data && (m_busy || slave_busy)) begin
        spi_ctrl[`STW_SPI_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // two-wire hardware slave event decode
  assign scl_rise = sclk_sy[1] && !scl_p;
  assign scl_fall = !sclk_sy[1] && scl_p;
  assign tw_start = sclk_sy[1] && scl_p && sda_p && !serial_data_pin_sy[1];
  assign tw_stop  = sclk_sy[1] && scl_p && !sda_p && serial_data_pin_sy[1];

  // hardware slave: address, ack, then bytes in the addressed direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tw_state    <= stw_pkg::stw_tw_idle;
      tw_bcnt     <= 4'd0;
      tw_sh       <= 8'h00;
      tw_drv_low  <= 1'b0;
      tw_dir      <= 1'b0;
      tw_set_flag <= 1'b0;
      tw_load     <= 1'b0;
    end else if (ce) begin
      tw_set_flag <= 1'b0;
      tw_load     <= 1'b0;
      if (!tw_hw || tw_ctrl[`STW_TW_RESET_BIT]) begin
        tw_state   <= stw_pkg::stw_tw_idle;
        tw_drv_low <= 1'b0;
        tw_dir     <= 1'b0;
      end else if (tw_stop) begin
        tw_state   <= stw_pkg::stw_tw_idle;
        tw_drv_low <= 1'b0;
        tw_dir     <= 1'b0;
      end else if (tw_start) begin
        tw_state   <= stw_pkg::stw_tw_addr;
        tw_bcnt    <= 4'd0;
        tw_drv_low <= 1'b0;
      end else begin
        case (tw_state)
          stw_pkg::stw_tw_addr, stw_pkg::stw_tw_rx: begin
            if (scl_rise) begin
              tw_sh   <= {tw_sh[6:0], serial_data_pin_sy[1]};
              tw_bcnt <= tw_bcnt + 4'd1;
            end else if (scl_fall && tw_bcnt == 4'd8) begin
              if (tw_state == stw_pkg::stw_tw_rx) begin
                tw_load     <= 1'b1;
                tw_set_flag <= 1'b1;
                tw_drv_low  <= 1'b1;
                tw_state    <= stw_pkg::stw_tw_rx_ack;
              end else if (tw_sh[7:1] == `STW_TW_SLAVE_ADDR) begin
                tw_dir     <= tw_sh[0];
                tw_drv_low <= 1'b1;
                tw_state   <= stw_pkg::stw_tw_addr_ack;
              end else begin
                tw_state <= stw_pkg::stw_tw_idle;
              end
            end
          end
          stw_pkg::stw_tw_addr_ack, stw_pkg::stw_tw_rx_ack: begin
            if (scl_fall) begin
              tw_bcnt <= 4'd0;
              if (tw_dir) begin
                tw_sh      <= {tw_data[6:0], 1'b0};
                tw_drv_low <= !tw_data[7];
                tw_state   <= stw_pkg::stw_tw_tx;
              end else begin
                tw_drv_low <= 1'b0;
                tw_state   <= stw_pkg::stw_tw_rx;
              end
            end
          end
          stw_pkg::stw_tw_tx: begin
            if (scl_fall) begin
              tw_bcnt <= tw_bcnt + 4'd1;
              if (tw_bcnt == 4'd7) begin
                tw_drv_low  <= 1'b0;
                tw_set_flag <= 1'b1;
                tw_state    <= stw_pkg::stw_tw_tx_ack;
              end else begin
                tw_drv_low <= !tw_sh[7];
                tw_sh      <= {tw_sh[6:0], 1'b0};
              end
            end
          end
          stw_pkg::stw_tw_tx_ack: begin
            if (scl_rise && serial_data_pin_sy[1]) begin
              tw_dir   <= 1'b0; // master refused further bytes
              tw_state <= stw_pkg::stw_tw_idle;
            end else if (scl_fall) begin
              tw_state <= stw_pkg::stw_tw_addr_ack;
            end
          end
          default: tw_state <= stw_pkg::stw_tw_idle;
        endcase
      end
    end
  end

  // two-wire data register: received bytes or software writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tw_data <= `STW_RST_TW_DATA;
    end else if (ce) begin
      if (tw_load) begin
        tw_data <= tw_sh;
      end else if (wr_tw_data) begin
        tw_data <= sfr_wdata;
      end
    end
  end

  // two-wire control; flag set wins over a read in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tw_ctrl <= `STW_RST_TW_CTRL;
    end else if (ce) begin
      if (wr_tw_ctrl) begin
        tw_ctrl[7:5] <= sfr_wdata[7:5];
        tw_ctrl[3:2] <= sfr_wdata[3:2];
      end
      if (tw_sw && !tw_ctrl[`STW_TW_MDE_BIT] && scl_rise) begin
        tw_ctrl[`STW_TW_MDI_BIT] <= serial_data_pin_sy[1];
      end
      tw_ctrl[`STW_TW_DIR_BIT] <= tw_dir;
      if (tw_set_flag) begin
        tw_ctrl[`STW_TW_FLAG_BIT] <= 1'b1;
      end else if (rd_tw_data || wr_tw_data) begin
        tw_ctrl[`STW_TW_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // pin drivers registered; one interface owns the pins at a time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_out  <= 1'b0;
      sclk_oe   <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe  <= 1'b0;
      miso_oe   <= 1'b0;
    end else if (ce) begin
      if (spi_en) begin
        sclk_out  <= m_sclk;
        sclk_oe   <= master;
        serial_data_pin_out <= m_mosi;
        serial_data_pin_oe  <= master;
        miso_oe   <= !master && !ss_sy[1];
      end else if (tw_sw) begin
        sclk_out  <= tw_ctrl[`STW_TW_MCO_BIT];
        sclk_oe   <= 1'b1;
        serial_data_pin_out <= tw_ctrl[`STW_TW_MDO_BIT];
        serial_data_pin_oe  <= tw_ctrl[`STW_TW_MDE_BIT];
        miso_oe   <= 1'b0;
      end else begin
        sclk_out  <= 1'b0;
        sclk_oe   <= 1'b0;
        serial_data_pin_out <= 1'b0; // open drain: only ever pulls low
        serial_data_pin_oe  <= tw_drv_low;
        miso_oe   <= 1'b0;
      end
    end
  end

  // slave launch bit goes straight out; it lives on the link clock
  assign miso_out = sl_miso;

  // registered read port; slave role shows select level in bit 0
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      if (sfr_addr == `STW_ADDR_SPI_CTRL) begin
        sfr_rdata <= master ? spi_ctrl : {spi_ctrl[7:1], ss_sy[1]};
      end else if (sfr_addr == `STW_ADDR_SPI_DATA) begin
        sfr_rdata <= spi_data;
      end else if (sfr_addr == `STW_ADDR_TW_CTRL) begin
        sfr_rdata <= tw_ctrl;
      end else if (sfr_addr == `STW_ADDR_TW_DATA) begin
        sfr_rdata <= tw_data;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // helper: clock toggles seen during one master burst
  logic [4:0] tog_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog_cnt <= 5'd0;
    end else if (ce) begin
      if (!m_busy) begin
        tog_cnt <= 5'd0;
      end else if (m_hcnt == half_period - 6'd1) begin
        tog_cnt <= tog_cnt + 5'd1;
      end
    end
  end

  sequence burst_end_s;
    m_busy ##1 !m_busy;
  endsequence

  burst_eight_clocks_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && m_busy && $past(ce) ##0 burst_end_s |-> tog_cnt == 5'd16)
    else $error("master burst did not have sixteen edges");
  rate_half_period_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && m_busy && $past(m_busy) && $changed(m_sclk) |-> $past(m_hcnt) == half_period - 6'd1)
    else $error("serial clock half period wrong");
  master_no_select_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && spi_en && master ##1 ce |-> !miso_oe)
    else $error("miso driven in master role");
  done_loads_data_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && m_done ##1 ce |-> spi_ctrl[`STW_SPI_DONE_BIT] && spi_data == $past(m_sh))
    else $error("end of burst did not flag and load data");
  collision_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_spi_data && m_busy |=> spi_ctrl[`STW_SPI_WRITE_COLLISION_FLAG_BIT])
    else $error("write during transfer not flagged");
  slave_full_byte_a: assert property (@(posedge clk) disable iff (!nrst)
    $changed(spi_data) |-> $past(m_done) || $past(sl_complete))
    else $error("shift data changed without a complete byte");
  sw_data_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && tw_sw ##1 ce |-> serial_data_pin_oe == $past(tw_ctrl[6]) && serial_data_pin_out == $past(tw_ctrl[7]))
    else $error("software data pin not following control bits");
  sw_clock_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && tw_sw ##1 ce |-> sclk_oe && sclk_out == $past(tw_ctrl[5]))
    else $error("software clock pin not following control bit");
  byte_flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_tw_data && !tw_set_flag |=> !tw_ctrl[`STW_TW_FLAG_BIT])
    else $error("two-wire data read did not clear byte flag");
  reset_holds_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && tw_hw && tw_ctrl[`STW_TW_RESET_BIT] |=>
    tw_state == stw_pkg::stw_tw_idle && !tw_drv_low)
    else $error("two-wire slave active while held in reset");
  idle_level_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && spi_en && master && !m_busy && $past(ce) && $past(!m_busy) |=> m_sclk == $past(clock_idle_level))
    else $error("serial clock not at idle level");
endmodule
`default_nettype wire

// *** bench/stw_spi_dev.sv ***
// behavioural spi slave device facing the master role
`default_nettype none
module stw_spi_dev #(
  parameter logic [7:0] REPLY = 8'h3c
) (
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output int              edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  initial begin
    sh = REPLY;
    edges = 0;
  end
  assign miso = sh[7];
  // sample on the rising edge, idle low with trailing launch
  always @(posedge sclk) begin
    rx_byte <= {rx_byte[6:0], mosi};
    edges <= edges + 1;
  end
  // shifted-in bits toggle, so stale data never looks valid
  always @(negedge sclk) begin
    sh <= {sh[6:0], ~sh[0]};
  end
endmodule
`default_nettype wire

// *** bench/stw_serial_port_tb_top.sv ***
// self-checking bench for the serial port
`default_nettype none
`include "stw_regs.svh"
module stw_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ss_n = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d, got;
  logic sclk_out, sclk_oe, serial_data_pin_out, serial_data_pin_oe, miso_out, miso_oe, miso_in;
  logic sclk_ext = 1'b0, serial_data_pin_ext = 1'b0;
  wire logic sclk_in = sclk_oe ? sclk_out : sclk_ext;
  wire logic serial_data_pin_in = serial_data_pin_oe ? serial_data_pin_out : serial_data_pin_ext;
  logic [7:0] rx_byte, pat;
  logic s;
  int edges, e0, failures = 0, tests_run = 0, cycles = 0, i, m;
  logic [7:0] addrs [5] = '{`STW_ADDR_SPI_CTRL, `STW_ADDR_SPI_DATA, `STW_ADDR_TW_CTRL,
                            `STW_ADDR_TW_DATA, 8'h00};
  // slave role after reset shows the idle-high select level in bit 0
  logic [7:0] rsts [5] = '{`STW_RST_SPI_CTRL | 8'h01, `STW_RST_SPI_DATA, `STW_RST_TW_CTRL,
                           `STW_RST_TW_DATA, 8'h00};
  always #4 clk = ~clk;
  stw_serial_port dut (.clk(clk), .nrst(nrst), .ce(1'b1), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_data_pin_in(serial_data_pin_in),
    .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe), .miso_in(miso_in), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n(ss_n));
  stw_spi_dev dev (.sclk(sclk_in), .mosi(serial_data_pin_in), .miso(miso_in), .rx_byte(rx_byte),
    .edges(edges));
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  // read data is registered, so look just after the taking edge
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask
  // one two-wire bit from the far side; returns the pin level while the clock is high
  task tw_bit(input logic b, output logic lvl);
    serial_data_pin_ext <= b;
    repeat (4) @(posedge clk);
    sclk_ext <= 1'b1;
    repeat (4) @(posedge clk);
    lvl = serial_data_pin_in;
    sclk_ext <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task stop_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // reset values, unmapped address reads zero
    for (i = 0; i < 5; i++) begin
      rd(addrs[i], d);
      chk("reset value", d, rsts[i]);
    end
    // master burst with a colliding write in mid-transfer
    wr(`STW_ADDR_SPI_CTRL, 8'h30);
    e0 = edges;
    wr(`STW_ADDR_SPI_DATA, 8'ha5);
    wr(`STW_ADDR_SPI_DATA, 8'hff);
    d = 8'h00;
    for (i = 0; i < 100 && d[7] !== 1'b1; i++) rd(`STW_ADDR_SPI_CTRL, d);
    chk("master ctrl", d, 8'hf0);
    chk("clock count", 8'(edges - e0), 8'h08);
    chk("sent byte", rx_byte, 8'ha5);
    rd(`STW_ADDR_SPI_DATA, d);
    chk("master data", d, 8'h3c);
    rd(`STW_ADDR_SPI_CTRL, d);
    chk("done cleared", d, 8'h70);
    wr(`STW_ADDR_SPI_CTRL, 8'h30);
    rd(`STW_ADDR_SPI_CTRL, d);
    chk("write_collision_flag cleared", d, 8'h30);
    // slave role in both phases, link clock at 80 ns; phase 0 ends only on release
    for (m = 1; m >= 0; m--) begin
      pat = m[0] ? 8'h5a : 8'hc3;
      wr(`STW_ADDR_SPI_CTRL, m[0] ? 8'h24 : 8'h20);
      wr(`STW_ADDR_SPI_DATA, ~pat);
      @(posedge clk) ss_n <= 1'b0;
      #13;
      for (i = 7; i >= 0; i--) begin
        serial_data_pin_ext = 1'(pat >> i);
        #1;
        if (m == 0) got[i] = miso_out; // phase 0 samples before the rising edge
        sclk_ext = 1'b1;
        #40;
        sclk_ext = 1'b0;
        if (m == 1) got[i] = miso_out;
        #39;
      end
      repeat (20) @(posedge clk);
      rd(`STW_ADDR_SPI_CTRL, d);
      chk("early done", d & 8'h80, m[0] ? 8'h80 : 8'h00);
      chk("miso enable", {7'h00, miso_oe}, 8'h01);
      @(posedge clk) ss_n <= 1'b1;
      repeat (20) @(posedge clk);
      chk("miso release", {7'h00, miso_oe}, 8'h00);
      rd(`STW_ADDR_SPI_CTRL, d);
      chk("slave done", d & 8'h81, 8'h81);
      chk("slave sent", got, ~pat);
      rd(`STW_ADDR_SPI_DATA, d);
      chk("slave data", d, pat);
    end
    // two-wire software master on the shared pins
    wr(`STW_ADDR_SPI_CTRL, 8'h00);
    wr(`STW_ADDR_TW_CTRL, 8'he8);
    repeat (2) @(posedge clk);
    chk("sw drive", {5'h00, serial_data_pin_out, serial_data_pin_oe, sclk_out}, 8'h07);
    for (i = 1; i >= 0; i--) begin
      wr(`STW_ADDR_TW_CTRL, 8'h08);
      repeat (2) @(posedge clk);
      chk("sw release", {6'h00, serial_data_pin_oe, sclk_out}, 8'h00);
      serial_data_pin_ext <= i[0];
      wr(`STW_ADDR_TW_CTRL, 8'h28);
      repeat (6) @(posedge clk);
      rd(`STW_ADDR_TW_CTRL, d);
      chk("sw data in", d & 8'h10, i[0] ? 8'h10 : 8'h00);
    end
    // two-wire data register round trip
    wr(`STW_ADDR_TW_DATA, 8'h5c);
    rd(`STW_ADDR_TW_DATA, d);
    chk("tw data", d, 8'h5c);
    // hardware slave takes one byte written to its fixed address
    wr(`STW_ADDR_TW_CTRL, 8'h00);
    serial_data_pin_ext <= 1'b1;
    sclk_ext <= 1'b1;
    repeat (6) @(posedge clk);
    serial_data_pin_ext <= 1'b0; // start condition
    repeat (6) @(posedge clk);
    sclk_ext <= 1'b0;
    for (i = 7; i >= 0; i--) tw_bit(1'(8'haa >> i), s);
    tw_bit(1'b1, s);
    chk("addr ack", {7'h00, s}, 8'h00);
    for (i = 7; i >= 0; i--) tw_bit(1'(8'hc6 >> i), s);
    rd(`STW_ADDR_TW_CTRL, d);
    chk("rx flag", d & 8'h03, 8'h01);
    tw_bit(1'b1, s);
    chk("data ack", {7'h00, s}, 8'h00);
    rd(`STW_ADDR_TW_DATA, d);
    chk("rx byte", d, 8'hc6);
    rd(`STW_ADDR_TW_CTRL, d);
    chk("flag cleared", d & 8'h01, 8'h00);
    serial_data_pin_ext <= 1'b0;
    sclk_ext <= 1'b1;
    repeat (6) @(posedge clk);
    serial_data_pin_ext <= 1'b1; // stop condition
    repeat (6) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
